// ==== verilog/conv_ctrl_params.svh ====
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// Byte offsets of the register map
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_EVENT_CONTROL 4'h2
`define OFS_IRQ_ENABLE_CLEAR 4'h4
`define OFS_IRQ_ENABLE_SET 4'h5
`define OFS_IRQ_FLAGS 4'h6
`define OFS_SYNC_STATUS 4'h7
`define OFS_CONVERSION_VALUE 4'h8
`define OFS_STAGING_BUFFER 4'hC

// Word indices on the bus
`define WORD_CONTROL 2'h0
`define WORD_IRQ 2'h1
`define WORD_VALUE 2'h2
`define WORD_STAGING 2'h3

// Control A fields
`define CA_SOFT_RESET 0
`define CA_ENABLE 1
`define CA_RUN_IN_STANDBY 2

// Control B fields
`define CB_EXT_OUT_EN 0
`define CB_INT_OUT_EN 1
`define CB_LEFT_ALIGN 2
`define CB_PUMP_DISABLE 3
`define CB_BUF_PROTECT_BYPASS 4
`define CB_REF_SEL_LO 6
`define CB_REF_SEL_HI 7

// Event control, irq and status fields
`define EV_START_IN 0
`define EV_EMPTY_OUT 1
`define IRQ_UNDERRUN 0
`define IRQ_EMPTY 1
`define IRQ_SYNC_READY 2
`define ST_SYNC_BUSY 7

// Reset values
`define RST_CONTROL_B 8'h00
`define RST_BYTE 8'h00
`define RST_VALUE 16'h0000

// Sync latency between bus and converter side, in clocks
`define SYNC_CYCLES 4

`endif

// ==== verilog/conv_ctrl_pkg.sv ====
package conv_ctrl_pkg;

   // Reference choices of control B
   typedef enum logic [1:0] {
      internal_reference = 2'h0,
      analog_supply_reference = 2'h1,
      external_reference = 2'h2,
      reference_reserved = 2'h3
   } ref_sel_t;

   // Sync engine states
   typedef enum logic {
      SYNC_IDLE,
      SYNC_BUSY
   } sync_state_t;

endpackage

// ==== verilog/dac_control_registers.sv ====
`timescale 1ns/1ps
`include "conv_ctrl_params.svh"

// What this block does
// (R1) Writing 1 to the soft reset bit returns every register to reset and disables the converter.
// (R2) A write that sets the soft reset bit discards every other field of that access.
// (R3) The soft reset bit and the busy flag stay set together until the reset completes.
// (R4) The enable bit reads back at once while busy stays set until the change takes effect.
// (R5) Run-in-standby is not synchronized and keeps the output buffer alive in standby.
// (R6) Control B accepts writes only while the enable bit reads 0, even if the converter side has not yet seen the disable.
// (R7) Protected registers reject writes while the access controller protects the block.
// (R8) Control A, value and staging writes cross to the converter side through a sync step.
// (R9) Byte, half-word and word accesses work, each byte lane on its own.
// (R10) Reference select picks internal, analog supply or external reference; 3 is reserved.
// (R11) The protect bypass bit exempts the staging buffer from write protection.
// (R12) The pump disable bit forces the voltage pump off, else it runs automatically.
// (R13) The left align bit places the 10-bit code at the top of the 16-bit value.
// (R14) The internal output enable routes the converter output to the analog comparator.
// (R15) The external output enable lets the high-drive buffer drive the output pin.
// (R16) A synchronized write while busy is discarded and answered with an error.
// (R17) Reserved offsets and unused bits read zero and ignore writes.
module dac_control_registers
   import conv_ctrl_pkg::*;
#(
   parameter int SYNC_CYCLES = `SYNC_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [3:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic access_protect,
   input wire logic standby,
   input wire logic start_event_in,
   output logic converter_enabled,
   output logic [9:0] dac_code,
   output logic output_buffer_on,
   output logic internal_output_enable,
   output logic external_output_enable,
   output logic pump_disable,
   output ref_sel_t reference_select,
   output logic buffer_empty_event_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic soft_reset_bit, enable_bit, run_in_standby_bit, staging_full, sync_busy_flag;
   logic pend_enable, pend_value;
   logic [7:0] control_b, sync_cnt;
   logic [1:0] event_control;
   logic [2:0] irq_enable, irq_flags, flag_set, flag_clr;
   logic [15:0] conversion_value, staging_buffer, next_code;
   sync_state_t sync_state;

   logic wr;
   logic [1:0] word;
   logic ctrl_a_wr, ctrl_b_wr, ev_wr, ien_clr_wr, ien_set_wr, flag_wr;
   logic value_wr, staging_wr;
   logic protect_block, enable_block, busy_block, access_err, ok_wr;
   logic soft_reset_bit_hit, field_ok, sync_start, sync_done, soft_clear;
   logic start_take, start_underrun;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode, one aligned word per four printed offsets
   assign wr = psel & penable & pwrite;
   assign word = paddr[3:2];
   assign pready = 1'b1;
   // Each byte lane is its own register, except value and staging, which take lanes 0 and 1 together
   assign ctrl_a_wr = wr & (word == `WORD_CONTROL) & pstrb[0]; // see (R9)
   assign ctrl_b_wr = wr & (word == `WORD_CONTROL) & pstrb[1];
   assign ev_wr = wr & (word == `WORD_CONTROL) & pstrb[2];
   assign ien_clr_wr = wr & (word == `WORD_IRQ) & pstrb[0];
   assign ien_set_wr = wr & (word == `WORD_IRQ) & pstrb[1];
   assign flag_wr = wr & (word == `WORD_IRQ) & pstrb[2];
   assign value_wr = wr & (word == `WORD_VALUE) & (|pstrb[1:0]);
   assign staging_wr = wr & (word == `WORD_STAGING) & (|pstrb[1:0]);

   // Write refusal checks
   assign protect_block = access_protect
      & ~((word == `WORD_STAGING) & control_b[`CB_BUF_PROTECT_BYPASS]); // see (R7) see (R11)
   assign enable_block = ctrl_b_wr & enable_bit; // see (R6)
   assign busy_block = sync_busy_flag & (ctrl_a_wr | value_wr | staging_wr); // see (R16)
   assign access_err = wr & (protect_block | enable_block | busy_block);
   assign pslverr = access_err;
   assign ok_wr = wr & ~access_err;
   // Soft reset wins over every other field in the access
   assign soft_reset_bit_hit = ok_wr & ctrl_a_wr & pwdata[`CA_SOFT_RESET]; // see (R2)
   assign field_ok = ok_wr & ~soft_reset_bit_hit;
   assign sync_start = ok_wr & (ctrl_a_wr | value_wr | staging_wr); // see (R8)

   ////////////////////////////////////////////////////////////////////////////////
   // Sync engine standing in for the crossing to the converter side
   assign sync_done = (sync_state == SYNC_BUSY) && (sync_cnt == 8'h01);
   assign soft_clear = sync_done & soft_reset_bit; // see (R1)

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_state <= SYNC_IDLE;
         sync_cnt <= 8'h00;
      end else begin
         case (sync_state)
            SYNC_IDLE: begin
               if (sync_start) begin
                  sync_state <= SYNC_BUSY;
                  sync_cnt <= 8'(SYNC_CYCLES);
               end
            end
            SYNC_BUSY: begin
               sync_cnt <= sync_cnt - 8'h01;
               if (sync_done) begin
                  sync_state <= SYNC_IDLE;
               end
            end
            default: begin
               sync_state <= SYNC_IDLE;
               sync_cnt <= 8'h00;
            end
         endcase
      end
   end
   // Busy flag and soft reset bit fall together
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_busy_flag <= 1'b0;
         soft_reset_bit <= 1'b0;
      end else if (sync_done) begin
         sync_busy_flag <= 1'b0; // see (R3)
         soft_reset_bit <= 1'b0;
      end else if (sync_start) begin
         sync_busy_flag <= 1'b1;
         soft_reset_bit <= soft_reset_bit_hit;
      end
   end
   // Operations waiting on the far side
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pend_enable <= 1'b0;
         pend_value <= 1'b0;
      end else if (sync_done) begin
         pend_enable <= 1'b0;
         pend_value <= 1'b0;
      end else if (sync_start) begin
         pend_enable <= ctrl_a_wr & ~soft_reset_bit_hit;
         pend_value <= value_wr & ~soft_reset_bit_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control A and the effective enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         enable_bit <= 1'b0;
         run_in_standby_bit <= 1'b0;
      end else if (soft_reset_bit_hit) begin
         enable_bit <= 1'b0; // see (R1)
      end else if (soft_clear) begin
         enable_bit <= 1'b0;
         run_in_standby_bit <= 1'b0;
      end else if (field_ok & ctrl_a_wr) begin
         enable_bit <= pwdata[`CA_ENABLE]; // see (R4)
         run_in_standby_bit <= pwdata[`CA_RUN_IN_STANDBY]; // see (R5)
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         converter_enabled <= 1'b0;
      end else if (soft_clear) begin
         converter_enabled <= 1'b0;
      end else if (sync_done & pend_enable) begin
         converter_enabled <= enable_bit; // see (R4)
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control B, event control and irq enables
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         control_b <= `RST_CONTROL_B;
      end else if (soft_clear) begin
         control_b <= `RST_CONTROL_B;
      end else if (field_ok & ctrl_b_wr) begin
         control_b <= pwdata[15:8] & 8'hDF; // see (R17)
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         event_control <= 2'h0;
         irq_enable <= 3'h0;
      end else if (soft_clear) begin
         event_control <= 2'h0;
         irq_enable <= 3'h0;
      end else begin
         if (field_ok & ev_wr) begin
            event_control <= pwdata[17:16];
         end
         if (field_ok & (ien_clr_wr | ien_set_wr)) begin
            irq_enable <= (irq_enable & ~({3{ien_clr_wr}} & pwdata[2:0]))
               | ({3{ien_set_wr}} & pwdata[10:8]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Value and staging buffer, linked as a two-stage queue
   assign start_take = start_event_in & event_control[`EV_START_IN] & converter_enabled
      & ~sync_busy_flag & staging_full;
   assign start_underrun = start_event_in & event_control[`EV_START_IN] & converter_enabled
      & ~staging_full;
   assign next_code = start_take ? staging_buffer : conversion_value;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         conversion_value <= `RST_VALUE;
      end else if (soft_clear) begin
         conversion_value <= `RST_VALUE;
      end else if (field_ok & value_wr) begin
         if (pstrb[0]) begin
            conversion_value[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            conversion_value[15:8] <= pwdata[15:8];
         end
      end else if (start_take) begin
         conversion_value <= staging_buffer;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         staging_buffer <= `RST_VALUE;
         staging_full <= 1'b0;
      end else if (soft_clear) begin
         staging_buffer <= `RST_VALUE;
         staging_full <= 1'b0;
      end else if (field_ok & staging_wr) begin
         if (pstrb[0]) begin
            staging_buffer[7:0] <= pwdata[7:0];
         end
         if (pstrb[1]) begin
            staging_buffer[15:8] <= pwdata[15:8];
         end
         staging_full <= 1'b1;
      end else if (start_take) begin
         staging_full <= 1'b0;
      end
   end
   // Converter code follows committed value writes and buffer transfers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dac_code <= 10'h000;
      end else if (soft_clear) begin
         dac_code <= 10'h000;
      end else if ((sync_done & pend_value) | start_take) begin
         dac_code <= control_b[`CB_LEFT_ALIGN] ? next_code[15:6] : next_code[9:0]; // see (R13)
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Flags: hardware set wins over a software clear
   assign flag_set = {sync_done, start_take, start_underrun};
   assign flag_clr = (field_ok & flag_wr) ? pwdata[18:16] : 3'h0;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_flags <= 3'h0;
      end else if (soft_clear) begin
         irq_flags <= 3'h0;
      end else begin
         irq_flags <= (irq_flags & ~(flag_clr | {1'b0, field_ok & staging_wr, 1'b0})) | flag_set;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         buffer_empty_event_out <= 1'b0;
      end else begin
         buffer_empty_event_out <= start_take & event_control[`EV_EMPTY_OUT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Analog side controls
   assign reference_select = ref_sel_t'(control_b[`CB_REF_SEL_HI:`CB_REF_SEL_LO]); // see (R10)
   assign pump_disable = control_b[`CB_PUMP_DISABLE]; // see (R12)
   assign internal_output_enable = converter_enabled & control_b[`CB_INT_OUT_EN]; // see (R14)
   assign external_output_enable = converter_enabled & control_b[`CB_EXT_OUT_EN]; // see (R15)
   assign output_buffer_on = external_output_enable & (~standby | run_in_standby_bit); // see (R5)

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         case (paddr[3:2])
            `WORD_CONTROL: prdata <= {8'h00, 6'h00, event_control, control_b,
               5'h00, run_in_standby_bit, enable_bit, soft_reset_bit}; // see (R17)
            `WORD_IRQ: prdata <= {sync_busy_flag, 7'h00, 5'h00, irq_flags,
               5'h00, irq_enable, 5'h00, irq_enable};
            `WORD_VALUE: prdata <= {16'h0000, conversion_value};
            `WORD_STAGING: prdata <= {16'h0000, staging_buffer};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_soft_reset_bit_completes;
      @(posedge mclk) disable iff (rst)
      soft_reset_bit_hit |-> ##SYNC_CYCLES sync_done
         ##1 (!sync_busy_flag && !soft_reset_bit && !converter_enabled);
   endproperty
   a_soft_reset_bit_completes: assert property (p_soft_reset_bit_completes) else $error("soft reset incomplete"); // see (R1)
   property p_soft_reset_bit_discards;
      @(posedge mclk) disable iff (rst)
      soft_reset_bit_hit |=> ($stable(control_b) && !enable_bit);
   endproperty
   a_soft_reset_bit_discards: assert property (p_soft_reset_bit_discards) else $error("field kept with reset"); // see (R2)
   property p_soft_reset_bit_pair;
      @(posedge mclk) disable iff (rst)
      soft_reset_bit |-> sync_busy_flag;
   endproperty
   a_soft_reset_bit_pair: assert property (p_soft_reset_bit_pair) else $error("reset bit without busy"); // see (R3)
   property p_enable_readback;
      @(posedge mclk) disable iff (rst)
      (field_ok && ctrl_a_wr) |=> (enable_bit == $past(pwdata[1]) && sync_busy_flag);
   endproperty
   a_enable_readback: assert property (p_enable_readback) else $error("enable not read back"); // see (R4)
   property p_ctrl_b_locked;
      @(posedge mclk) disable iff (rst)
      (ctrl_b_wr && enable_bit) |-> (pslverr ##1 $stable(control_b));
   endproperty
   a_ctrl_b_locked: assert property (p_ctrl_b_locked) else $error("control b written"); // see (R6)
   property p_protect;
      @(posedge mclk) disable iff (rst)
      (wr && access_protect && word != `WORD_STAGING) |-> pslverr;
   endproperty
   a_protect: assert property (p_protect) else $error("protected write taken"); // see (R7)
   property p_bypass;
      @(posedge mclk) disable iff (rst)
      (staging_wr && control_b[4] && !sync_busy_flag) |-> !pslverr;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypassed write refused"); // see (R11)
   property p_busy_refuse;
      @(posedge mclk) disable iff (rst)
      (sync_busy_flag && (value_wr || staging_wr)) |-> (pslverr ##1 $stable(staging_full));
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("busy write taken"); // see (R16)
   property p_standby_off;
      @(posedge mclk) disable iff (rst)
      (standby && !run_in_standby_bit) |-> !output_buffer_on;
   endproperty
   a_standby_off: assert property (p_standby_off) else $error("buffer on in standby"); // see (R5)
   property p_reserved_zero;
      @(posedge mclk) disable iff (rst)
      (psel && penable && !pwrite && word >= `WORD_VALUE) |-> (prdata[31:16] == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved reads nonzero"); // see (R17)

endmodule

// ==== verification/apb_host.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Software side of the register bus: two-cycle transfers, driven on falling edge
module apb_host (
   input wire logic mclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [3:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 4'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end

   // One transfer; answer taken at the edge that sees ready
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] rd, output logic err);
      int n;
      @(negedge mclk);
      psel = 1'b1;
      pwrite = wr;
      paddr = a;
      pwdata = d;
      pstrb = s;
      @(negedge mclk);
      penable = 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      @(negedge mclk);
      // Released lines show inverted leftovers, not the last request
      psel = 1'b0;
      penable = 1'b0;
      pwrite = ~pwrite;
      paddr = ~paddr;
      pwdata = ~pwdata;
      pstrb = 4'h0;
   endtask
endmodule

// ==== verification/tb_dac_control_registers.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
   $display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
////////////////////////////////////////////////////////////////////////////////
// Register map bench with a byte model of the map
module tb_dac_control_registers
   import conv_ctrl_pkg::*;
;
   localparam int SC = 4;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr;
   logic [3:0] paddr, pstrb;
   logic [31:0] pwdata, prdata;
   logic access_protect = 1'b0;
   logic standby = 1'b0;
   logic start_event_in = 1'b0;
   logic converter_enabled, output_buffer_on, buffer_empty_event_out;
   logic internal_output_enable, external_output_enable, pump_disable;
   logic [9:0] dac_code;
   ref_sel_t reference_select;
   logic [7:0] m [0:15];
   logic [7:0] v;
   logic [31:0] r;
   logic e;
   int errors = 0;
   int samples_checked = 0;

   // Clock
   always #5 mclk = ~mclk;

   dac_control_registers #(.SYNC_CYCLES(SC)) DUT (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .access_protect(access_protect),
      .standby(standby), .start_event_in(start_event_in),
      .converter_enabled(converter_enabled), .dac_code(dac_code),
      .output_buffer_on(output_buffer_on), .internal_output_enable(internal_output_enable),
      .external_output_enable(external_output_enable), .pump_disable(pump_disable),
      .reference_select(reference_select), .buffer_empty_event_out(buffer_empty_event_out));

   apb_host host (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb));

   ////////////////////////////////////////////////////////////////////////////////
   // Writable bits of each byte
   function automatic logic [7:0] wmask(input int idx);
      case (idx)
         0: return 8'h07;
         1: return 8'hDF;
         2: return 8'h03;
         3, 10, 11, 14, 15: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction

   // Write, check the refusal, update model when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic xe);
      logic [31:0] rr;
      logic ee;
      host.xfer(1'b1, a, d, s, rr, ee);
      `CHK(ee, xe)
      if (!xe) begin
         for (int i = 0; i < 4; i++) begin
            if (s[i]) m[a + i] = d[8 * i +: 8] & wmask(a + i);
         end
      end
   endtask

   // Read a word and compare with the model
   task automatic rdchk(input logic [3:0] a);
      logic [31:0] rr;
      logic ee;
      host.xfer(1'b0, a, 32'h0, 4'h0, rr, ee);
      `CHK(rr, {m[a + 3], m[a + 2], m[a + 1], m[a]})
   endtask

   // Poll the busy flag, bounded
   task automatic wait_idle();
      logic [31:0] rr;
      logic ee;
      for (int n = 0; n < 20; n++) begin
         host.xfer(1'b0, 4'h4, 32'h0, 4'h0, rr, ee);
         if (rr[31] === 1'b0) return;
      end
      `CHK(rr[31], 1'b0)
   endtask

   // Control B fields at the pins; output paths only while enabled
   task automatic chk_outs(input logic en);
      `CHK(reference_select, ref_sel_t'(m[1][7:6]))
      `CHK(pump_disable, m[1][3])
      `CHK(internal_output_enable, m[1][1] & en)
      `CHK(external_output_enable, m[1][0] & en)
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #200000;
      errors++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      foreach (m[i]) m[i] = 8'h00;
      v = 8'($urandom(32'h2761));
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      for (int a = 0; a < 16; a += 4) rdchk(4'(a));
      `CHK(converter_enabled, 1'b0)
      chk_outs(1'b0);
      $display("test reset_values done");
      // Every reference code, random other fields, one lane
      for (int i = 0; i < 4; i++) begin
         v = {2'(i), 6'($urandom())};
         wr(4'h0, {16'h0, v, 8'h0}, 4'b0010, 1'b0);
         rdchk(4'h0);
         chk_outs(1'b0);
      end
      wr(4'h0, {8'hA5, 8'hFF, 8'h50, 8'h00}, 4'b1110, 1'b0);
      rdchk(4'h0);
      $display("test control_b done");
      // Protection with and without the staging bypass
      access_protect = 1'b1;
      wr(4'hC, 32'h0155, 4'b0011, 1'b0);
      wr(4'hC, 32'h0156, 4'b0011, 1'b1);
      wait_idle();
      wr(4'h0, 32'h4100, 4'b0010, 1'b1);
      rdchk(4'h0);
      access_protect = 1'b0;
      // External output on, left aligned, bypass off
      wr(4'h0, 32'h0500, 4'b0010, 1'b0);
      access_protect = 1'b1;
      wr(4'hC, 32'h0157, 4'b0011, 1'b1);
      access_protect = 1'b0;
      rdchk(4'hC);
      $display("test protection done");
      // Enable in standby with run-in-standby clear
      standby = 1'b1;
      wr(4'h0, 32'h2, 4'b0001, 1'b0);
      `CHK(converter_enabled, 1'b0)
      rdchk(4'h0);
      wait_idle();
      `CHK(converter_enabled, 1'b1)
      `CHK(output_buffer_on, 1'b0)
      chk_outs(1'b1);
      wr(4'h0, 32'h0C00, 4'b0010, 1'b1);
      rdchk(4'h0);
      standby = 1'b0;
      @(negedge mclk);
      `CHK(output_buffer_on, 1'b1)
      $display("test enable done");
      // Random value write, code taken left aligned
      v = 8'($urandom());
      wr(4'h8, {16'h0, v, 8'h3F}, 4'b0011, 1'b0);
      wait_idle();
      `CHK(dac_code, {m[9], m[8]} >> 6)
      rdchk(4'h8);
      // Start event moves the staging word into the value
      @(negedge mclk);
      start_event_in = 1'b1;
      @(negedge mclk);
      start_event_in = 1'b0;
      `CHK(buffer_empty_event_out, 1'b1)
      `CHK(dac_code, {m[13], m[12]} >> 6)
      m[8] = m[12];
      m[9] = m[13];
      rdchk(4'h8);
      $display("test start_event done");
      // Soft reset with event control in the same access
      wr(4'h0, 32'h0000_0007, 4'b0101, 1'b0);
      host.xfer(1'b0, 4'h0, 32'h0, 4'h0, r, e);
      `CHK(r[0], 1'b1)
      `CHK({r[17:16], r[2:0]}, 5'h19)
      wait_idle();
      foreach (m[i]) m[i] = 8'h00;
      for (int a = 0; a < 16; a += 4) rdchk(4'(a));
      `CHK(converter_enabled, 1'b0)
      `CHK(dac_code, 10'h000)
      chk_outs(1'b0);
      $display("test soft_reset done");
      wrap_up();
   end
endmodule
